// ==== design/rsic_top.sv ====
// rsic_top: operating state sequencer, interrupt latching and output pin muxing
// assumes event inputs come from logic on clk_i; register strobes are single cycle
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
module rsic_top
    import rsic_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [N_LATCH-1:0]  evt_pulse_i,
    input  wire logic [N_AUTO-1:0]   auto_level_i,
    input  wire logic                data_i,
    input  wire logic                bit_sync_clock_i,
    input  wire logic                sys_clk_div_i,
    output logic [7:0]               reg_rdata_o,
    output logic                     out_pin_a_o,
    output logic                     out_pin_b_o,
    output logic                     out_pin_c_o,
    output logic                     out_pin_d_o,
    output logic                     xtal_on_o,
    output logic                     synth_on_o,
    output logic                     rf_on_o,
    output logic                     fifo_access_o,
    output logic                     nvm_access_o,
    output logic                     sleep_timer_on_o
);
    // whole state of the block in one record, apart from the user storage area
    typedef struct packed {
        rsic_state_t          st;
        logic [CNT_W-1:0]     cnt;
        logic                 por_active;
        rsic_state_t          goal;      // state a forward command finally aims at
        logic [N_LATCH-1:0]   en;
        logic [N_LATCH-1:0]   lat;
        logic [N_LATCH-1:0]   clr;
        logic [3:0]           sel_a;
        logic [3:0]           sel_b;
        logic [7:0]           pin_sel;
        logic [15:0]          xtal_cyc16;
        logic                 slp_en;
        logic [4:0]           nvm_adr;
        logic [7:0]           rdata;
        logic                 pin_a;
        logic                 pin_b;
        logic                 pin_c;
        logic                 pin_d;
        rsic_power_t          pwr;
    } rsic_regs_t;

    rsic_regs_t cur_ff;   // registered state
    rsic_regs_t nxt_ff;   // next-state copy
    rsic_req_t  req;      // bundled register request
    logic [7:0] nvm_mem [NVM_BYTES];  // user storage area, kept apart from config

    logic [N_SRC-1:0] src;     // all sources, active high
    logic             line_a;  // muxed irq line a
    logic             line_b;  // muxed irq line b
    logic [CNT_W-1:0] wake_cyc;  // crystal stabilising count in cycles
    logic             nvm_wr;    // user area write strobe

    assign req      = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
    assign src      = {auto_level_i, cur_ff.lat};
    assign wake_cyc = CNT_W'({cur_ff.xtal_cyc16, 4'h0});
    assign line_a   = src[cur_ff.sel_a];
    assign line_b   = src[cur_ff.sel_b];
    assign nvm_wr   = req.wr && req.addr == ADDR_NVM_DAT && cur_ff.st == ST_NVM;

    // next-state logic: sequencer, registers, irq latches, pin muxes
    always_comb begin
        nxt_ff      = cur_ff;
        nxt_ff.cnt  = cur_ff.cnt + CNT_W'(1);
        nxt_ff.clr  = '0;  // clear bits return to zero by themselves
        // state sequencing
        unique case (cur_ff.st)
            ST_POR: begin
                if (cur_ff.cnt == CNT_W'(POR_CYC - 1)) begin
                    nxt_ff.st  = ST_XTAL;
                    nxt_ff.cnt = '0;
                    nxt_ff.por_active = 1'b0;
                end
            end
            ST_XTAL: begin
                if (cur_ff.cnt == CNT_W'(XTAL_FIRST_CYC - 1)) begin
                    nxt_ff.st  = ST_CAL;
                    nxt_ff.cnt = '0;
                end
            end
            ST_CAL: begin
                if (cur_ff.cnt == CNT_W'(CAL_CYC - 1)) begin
                    nxt_ff.st  = ST_SLEEP;
                    nxt_ff.cnt = '0;
                end
            end
            ST_WAKE: begin
                if (cur_ff.cnt >= wake_cyc) begin
                    // a tune or receive goal walks on through tuning
                    nxt_ff.st  = (cur_ff.goal inside {ST_TUNE, ST_RX}) ? ST_TUNING : ST_STBY;
                    nxt_ff.cnt = '0;
                end
            end
            ST_TUNING: begin
                if (cur_ff.cnt == CNT_W'(TUNE_CYC - 1)) begin
                    nxt_ff.st  = (cur_ff.goal == ST_RX) ? ST_RXON : ST_TUNE;
                    nxt_ff.cnt = '0;
                end
            end
            ST_RXON: begin
                if (cur_ff.cnt == CNT_W'(RXON_CYC - 1)) begin
                    nxt_ff.st  = ST_RX;
                    nxt_ff.cnt = '0;
                end
            end
            ST_SLEEP: begin
                // sleep timer expiry wakes to standby
                if (cur_ff.slp_en && evt_pulse_i[6]) begin
                    nxt_ff.st  = ST_WAKE;
                    nxt_ff.goal = ST_STBY;  // timer wake stops in standby
                    nxt_ff.cnt = '0;
                end
            end
            ST_STBY, ST_TUNE, ST_RX, ST_NVM: begin
                nxt_ff.cnt = '0;  // settled states do not count
            end
            default: begin
                nxt_ff.st = ST_POR;  // illegal code recovers via power-up
            end
        endcase
        // state commands; forward steps pass through timed stages
        if (req.wr && req.addr == ADDR_OPCMD && cur_ff.st >= ST_SLEEP) begin
            nxt_ff.cnt = '0;
            if (req.wdata[4:0] == CMD_SLEEP) begin
                nxt_ff.st = ST_SLEEP;  // backward moves are immediate
            end else if (req.wdata[4:0] == CMD_STBY) begin
                nxt_ff.goal = ST_STBY;
                nxt_ff.st = (cur_ff.st == ST_SLEEP) ? ST_WAKE : ST_STBY;
            end else if (req.wdata[4:0] == CMD_TUNE) begin
                nxt_ff.goal = ST_TUNE;
                nxt_ff.st = (cur_ff.st == ST_SLEEP) ? ST_WAKE :
                            (cur_ff.st == ST_RX || cur_ff.st == ST_TUNE) ? ST_TUNE : ST_TUNING;
            end else if (req.wdata[4:0] == CMD_RX) begin
                // from sleep the whole chain is walked, host waits it out
                nxt_ff.goal = ST_RX;
                nxt_ff.st = (cur_ff.st == ST_SLEEP) ? ST_WAKE :
                            (cur_ff.st == ST_TUNE) ? ST_RXON :
                            (cur_ff.st == ST_RX) ? ST_RX : ST_TUNING;
            end else if (req.wdata[4:0] == CMD_NVM && cur_ff.st == ST_SLEEP) begin
                nxt_ff.st = ST_NVM;  // memory command accepted only from sleep, ignored elsewhere
            end else begin
                nxt_ff.st = cur_ff.st;  // unknown code ignored
            end
        end
        // soft reset restarts power-up from crystal start
        if (req.wr && req.addr == ADDR_RESTART && req.wdata == RESTART_KEY) begin
            nxt_ff.st  = ST_XTAL;
            nxt_ff.cnt = '0;
        end
        // configuration writes
        if (req.wr) begin
            unique case (req.addr)
                ADDR_IRQ_EN:   nxt_ff.en      = req.wdata;
                ADDR_IRQ_CLR:  nxt_ff.clr     = req.wdata;
                ADDR_LINE_SEL: begin
                    nxt_ff.sel_a = req.wdata[3:0];
                    nxt_ff.sel_b = req.wdata[7:4];
                end
                ADDR_PIN_SEL:  nxt_ff.pin_sel = req.wdata;
                ADDR_XTAL_LO:  nxt_ff.xtal_cyc16[7:0]  = req.wdata;
                ADDR_XTAL_HI:  nxt_ff.xtal_cyc16[15:8] = req.wdata;
                ADDR_SLP_CTL:  nxt_ff.slp_en  = req.wdata[0];
                ADDR_NVM_ADR:  nxt_ff.nvm_adr = req.wdata[4:0];
                default: ;
            endcase
        end
        // latched sources: clear then set, so a same-cycle event wins
        nxt_ff.lat = (cur_ff.lat & ~cur_ff.clr) | (evt_pulse_i & cur_ff.en);
        // clear bits stay high only in the cycle after a write to the clear register
        if (!(req.wr && req.addr == ADDR_IRQ_CLR)) begin
            nxt_ff.clr = '0;
        end
        // register read data, one cycle after the read strobe
        nxt_ff.rdata = '0;
        if (req.rd) begin
            unique case (req.addr)
                ADDR_STATUS:   nxt_ff.rdata = {3'h0, cur_ff.por_active, cur_ff.st};
                ADDR_IRQ_EN:   nxt_ff.rdata = cur_ff.en;
                ADDR_IRQ_STAT: nxt_ff.rdata = cur_ff.lat;
                ADDR_LINE_SEL: nxt_ff.rdata = {cur_ff.sel_b, cur_ff.sel_a};
                ADDR_PIN_SEL:  nxt_ff.rdata = cur_ff.pin_sel;
                ADDR_XTAL_LO:  nxt_ff.rdata = cur_ff.xtal_cyc16[7:0];
                ADDR_XTAL_HI:  nxt_ff.rdata = cur_ff.xtal_cyc16[15:8];
                ADDR_SLP_CTL:  nxt_ff.rdata = {7'h0, cur_ff.slp_en};
                ADDR_NVM_ADR:  nxt_ff.rdata = {3'h0, cur_ff.nvm_adr};
                ADDR_NVM_DAT:  nxt_ff.rdata = (cur_ff.st == ST_NVM) ?
                                              nvm_mem[cur_ff.nvm_adr] : 8'h00;
                default:       nxt_ff.rdata = 8'h00;  // unmapped reads zero
            endcase
        end
        // block power follows the state
        nxt_ff.pwr.xtal_on     = nxt_ff.st inside {ST_XTAL, ST_CAL, ST_WAKE, ST_STBY,
                                                  ST_TUNING, ST_TUNE, ST_RXON, ST_RX, ST_NVM};
        nxt_ff.pwr.synth_on    = nxt_ff.st inside {ST_TUNING, ST_TUNE, ST_RXON, ST_RX};
        nxt_ff.pwr.rf_on       = nxt_ff.st inside {ST_RX};
        nxt_ff.pwr.fifo_access = nxt_ff.st inside {ST_STBY, ST_TUNING, ST_TUNE, ST_RXON, ST_RX};
        nxt_ff.pwr.nvm_access  = nxt_ff.st == ST_NVM;
        // output pin muxes
        unique case (cur_ff.pin_sel[1:0])
            SEL_DEFAULT: nxt_ff.pin_a = ~cur_ff.por_active;
            SEL_LINE_A:  nxt_ff.pin_a = line_a;
            SEL_LINE_B:  nxt_ff.pin_a = line_b;
            SEL_ALT:     nxt_ff.pin_a = data_i;
        endcase
        unique case (cur_ff.pin_sel[3:2])
            SEL_DEFAULT: nxt_ff.pin_b = line_a;
            SEL_LINE_A:  nxt_ff.pin_b = line_a;
            SEL_LINE_B:  nxt_ff.pin_b = line_b;
            SEL_ALT:     nxt_ff.pin_b = bit_sync_clock_i;
        endcase
        unique case (cur_ff.pin_sel[5:4])
            SEL_DEFAULT: nxt_ff.pin_c = sys_clk_div_i & cur_ff.pwr.xtal_on;
            SEL_LINE_A:  nxt_ff.pin_c = line_a;
            SEL_LINE_B:  nxt_ff.pin_c = line_b;
            SEL_ALT:     nxt_ff.pin_c = data_i;
        endcase
        unique case (cur_ff.pin_sel[7:6])
            SEL_DEFAULT: nxt_ff.pin_d = data_i;
            SEL_LINE_A:  nxt_ff.pin_d = line_a;
            SEL_LINE_B:  nxt_ff.pin_d = line_b;
            SEL_ALT:     nxt_ff.pin_d = bit_sync_clock_i;
        endcase
    end

    // state register; por flag set only by the hard reset
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cur_ff            <= '0;
            cur_ff.st         <= ST_POR;
            cur_ff.por_active <= 1'b1;
            cur_ff.xtal_cyc16 <= XTAL_RESET_CYC;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // user area storage, survives soft reset
    always_ff @(posedge clk_i) begin
        if (nvm_wr) begin
            nvm_mem[cur_ff.nvm_adr] <= req.wdata;
        end
    end

    assign reg_rdata_o      = cur_ff.rdata;
    assign out_pin_a_o      = cur_ff.pin_a;
    assign out_pin_b_o      = cur_ff.pin_b;
    assign out_pin_c_o      = cur_ff.pin_c;
    assign out_pin_d_o      = cur_ff.pin_d;
    assign xtal_on_o        = cur_ff.pwr.xtal_on;
    assign synth_on_o       = cur_ff.pwr.synth_on;
    assign rf_on_o          = cur_ff.pwr.rf_on;
    assign fifo_access_o    = cur_ff.pwr.fifo_access;
    assign nvm_access_o     = cur_ff.pwr.nvm_access;
    assign sleep_timer_on_o = cur_ff.slp_en;
endmodule : rsic_top

// ==== pkg/rsic_pkg.sv ====
// rsic_pkg: constants, states and carriers for the receiver state and irq control block
// assumes a 200 MHz system clock and a plain address/strobe register port
package rsic_pkg;
    // clock rate in kHz for time-to-cycle conversion
    localparam int unsigned CLK_KHZ        = 200000;
    // times as printed, in microseconds
    localparam int unsigned POR_TIME_US    = 500;
    localparam int unsigned XTAL_FIRST_US  = 2500;
    localparam int unsigned CAL_TIME_US    = 6500;
    localparam int unsigned TUNE_TIME_US   = 300;
    localparam int unsigned RXON_TIME_US   = 20;
    // derived cycle counts (exact multiples, no rounding needed)
    localparam int unsigned POR_CYC        = POR_TIME_US * CLK_KHZ / 1000;
    localparam int unsigned XTAL_FIRST_CYC = XTAL_FIRST_US * CLK_KHZ / 1000;
    localparam int unsigned CAL_CYC        = CAL_TIME_US * CLK_KHZ / 1000;
    localparam int unsigned TUNE_CYC       = TUNE_TIME_US * CLK_KHZ / 1000;
    localparam int unsigned RXON_CYC       = RXON_TIME_US * CLK_KHZ / 1000;
    localparam int unsigned CNT_W          = 24;

    // register offsets
    localparam logic [7:0] ADDR_OPCMD    = 8'h00;
    localparam logic [7:0] ADDR_RESTART  = 8'h01;
    localparam logic [7:0] ADDR_STATUS   = 8'h02;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h03;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h05;
    localparam logic [7:0] ADDR_LINE_SEL = 8'h06;
    localparam logic [7:0] ADDR_PIN_SEL  = 8'h07;
    localparam logic [7:0] ADDR_XTAL_LO  = 8'h08;
    localparam logic [7:0] ADDR_XTAL_HI  = 8'h09;
    localparam logic [7:0] ADDR_SLP_CTL  = 8'h0a;
    localparam logic [7:0] ADDR_NVM_ADR  = 8'h0b;
    localparam logic [7:0] ADDR_NVM_DAT  = 8'h0c;

    // five-bit state command codes and the eight-bit soft reset key
    localparam logic [4:0] CMD_SLEEP = 5'h01;
    localparam logic [4:0] CMD_STBY  = 5'h02;
    localparam logic [4:0] CMD_TUNE  = 5'h04;
    localparam logic [4:0] CMD_RX    = 5'h08;
    localparam logic [4:0] CMD_NVM   = 5'h10;
    localparam logic [7:0] RESTART_KEY = 8'hff;

    // irq source indices: 0..7 host-cleared, 8..13 automatic
    localparam int unsigned N_LATCH = 8;
    localparam int unsigned N_AUTO  = 6;
    localparam int unsigned N_SRC   = N_LATCH + N_AUTO;
    localparam logic [15:0] XTAL_RESET_CYC = 16'h0fa0;  // default xtal stabilising count /16

    // pin select codes and user storage size in bytes
    localparam logic [1:0] SEL_DEFAULT = 2'h0;
    localparam logic [1:0] SEL_LINE_A  = 2'h1;
    localparam logic [1:0] SEL_LINE_B  = 2'h2;
    localparam logic [1:0] SEL_ALT     = 2'h3;
    localparam int unsigned NVM_BYTES  = 32;

    typedef enum logic [3:0] {
        ST_POR   = 4'h0,
        ST_XTAL  = 4'h1,
        ST_CAL   = 4'h2,
        ST_SLEEP = 4'h3,
        ST_WAKE  = 4'h4,
        ST_STBY  = 4'h5,
        ST_TUNING= 4'h6,
        ST_TUNE  = 4'h7,
        ST_RXON  = 4'h8,
        ST_RX    = 4'h9,
        ST_NVM   = 4'ha
    } rsic_state_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rsic_req_t;

    // block power enables
    typedef struct packed {
        logic xtal_on;
        logic synth_on;
        logic rf_on;
        logic fifo_access;
        logic nvm_access;
    } rsic_power_t;
endpackage : rsic_pkg

// ==== tb/rsic_top_monitor.sv ====
// rsic_top_monitor: concurrent checks on the state, power and read ports
// assumes it is bound into rsic_top and sees only that module's ports
`timescale 1ns/100ps
module rsic_top_monitor
    import rsic_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_rdata_o,
    input  wire logic       out_pin_a_o,
    input  wire logic       xtal_on_o,
    input  wire logic       synth_on_o,
    input  wire logic       rf_on_o,
    input  wire logic       fifo_access_o,
    input  wire logic       nvm_access_o
);
    localparam int unsigned PUP_END = POR_CYC + XTAL_FIRST_CYC + CAL_CYC; // end of power-up
    logic [23:0] up_cnt_ff;  // cycles since reset release, saturates
    logic        restart_w;  // soft reset key seen on the port
    assign restart_w = reg_wr_i && reg_addr_i == ADDR_RESTART && reg_wdata_i == RESTART_KEY;
    // age counter; saturation keeps the power-up windows from wrapping
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) up_cnt_ff <= '0;
        else if (up_cnt_ff != '1) up_cnt_ff <= up_cnt_ff + 24'h000001;
    end
    default clocking mon_cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    por_pin_low_a: assert property (up_cnt_ff < POR_CYC |-> !out_pin_a_o)
        else $error("host reset released during power-on reset");
    por_xtal_off_a: assert property (up_cnt_ff < POR_CYC |-> !xtal_on_o)
        else $error("crystal started before power-on reset ended");
    pup_xtal_on_a: assert property (up_cnt_ff >= POR_CYC + 4 && up_cnt_ff < PUP_END
        |-> xtal_on_o) else $error("crystal off during start-up or calibration");
    pup_quiet_a: assert property (up_cnt_ff < PUP_END
        |-> !synth_on_o && !rf_on_o && !fifo_access_o) else $error("blocks on in power-up");
    rx_power_a: assert property (rf_on_o |-> synth_on_o && xtal_on_o)
        else $error("front-end on without synthesizer and crystal");
    fifo_xtal_a: assert property (fifo_access_o |-> xtal_on_o)
        else $error("queue accessible with crystal off");
    nvm_alone_a: assert property (nvm_access_o |-> !fifo_access_o && !synth_on_o)
        else $error("memory state overlaps queue or synthesizer");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside the read answer cycle");
    tune_order_a: assert property ($rose(synth_on_o) |-> $past(xtal_on_o))
        else $error("synthesizer started before crystal");
    restart_pup_a: assert property (restart_w
        |-> ##2 xtal_on_o && !synth_on_o && !rf_on_o) else $error("soft reset not in power-up");
    cover property (rf_on_o);
    cover property (nvm_access_o);
    cover property (restart_w);
endmodule : rsic_top_monitor
bind rsic_top rsic_top_monitor u_mon (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .out_pin_a_o(out_pin_a_o), .xtal_on_o(xtal_on_o),
    .synth_on_o(synth_on_o), .rf_on_o(rf_on_o), .fifo_access_o(fifo_access_o),
    .nvm_access_o(nvm_access_o)
);

// ==== tb/rsic_host_model.sv ====
// rsic_host_model: far-side event, level and pin-source drivers
// assumes the bench calls its tasks from the clk_i domain
`timescale 1ns/100ps
module rsic_host_model
    import rsic_pkg::*;
(
    input  wire logic              clk_i,
    output logic [N_LATCH-1:0]     evt_pulse_o,
    output logic [N_AUTO-1:0]      auto_level_o,
    output logic                   data_o,
    output logic                   bit_clk_o,
    output logic                   clk_div_o
);
    // quiet sources from time zero
    initial begin
        evt_pulse_o  = '0;
        auto_level_o = '0;
        data_o       = 1'b0;
        bit_clk_o    = 1'b0;
        clk_div_o    = 1'b0;
    end
    // single-cycle event; callers get a gap edge so pulses never merge
    task automatic fire(input int idx);
        @(posedge clk_i);
        evt_pulse_o <= {{(N_LATCH-1){1'b0}}, 1'b1} << idx;
        @(posedge clk_i);
        evt_pulse_o <= '0;
    endtask : fire
    // auto sources are levels held until changed
    task automatic set_auto(input logic [N_AUTO-1:0] lv);
        @(posedge clk_i);
        auto_level_o <= lv;
    endtask : set_auto
    // data, bit clock and clock-out sources as plain levels
    task automatic set_lines(input logic d, input logic b, input logic c);
        @(posedge clk_i);
        data_o    <= d;
        bit_clk_o <= b;
        clk_div_o <= c;
    endtask : set_lines
endmodule : rsic_host_model

// ==== tb/rsic_top_bench.sv ====
// rsic_top_bench: register-level tests of sequencer, interrupts and pin muxes
// assumes host model drives the sources; power-up alone is about 1.9M cycles
`timescale 1ns/100ps
module rsic_top_bench
    import rsic_pkg::*;
;
    localparam int unsigned LIMIT = 2200000;  // power-up plus tune and margin
    logic clk_i, reset_n_i, reg_wr, reg_rd;   // clock, reset, strobes
    logic [7:0] reg_addr, reg_wdata, rdata, v; // bus and read result
    logic [N_LATCH-1:0] evt;                   // event pulses
    logic [N_AUTO-1:0]  lvl;                   // auto levels
    logic dat, bclk, cdiv, pin_a, pin_b, pin_c, pin_d;
    logic xtal_on, synth_on, rf_on, fifo_acc, nvm_acc, slp_on;
    int unsigned mismatches = 0, check_count = 0, cyc_cnt = 0;
    rsic_host_model u_host (.clk_i(clk_i), .evt_pulse_o(evt), .auto_level_o(lvl),
        .data_o(dat), .bit_clk_o(bclk), .clk_div_o(cdiv));
    rsic_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .evt_pulse_i(evt),
        .auto_level_i(lvl), .data_i(dat), .bit_sync_clock_i(bclk), .sys_clk_div_i(cdiv),
        .reg_rdata_o(rdata), .out_pin_a_o(pin_a), .out_pin_b_o(pin_b), .out_pin_c_o(pin_c),
        .out_pin_d_o(pin_d), .xtal_on_o(xtal_on), .synth_on_o(synth_on), .rf_on_o(rf_on),
        .fifo_access_o(fifo_acc), .nvm_access_o(nvm_acc), .sleep_timer_on_o(slp_on));
    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // hang guard
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // wait n edges, then step past them so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    // one-cycle write strobe; the lowering edge keeps calls from colliding
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_i);
        reg_wr    <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_i);
        reg_rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic st(input rsic_state_t s);
        logic [7:0] d;
        rd(ADDR_STATUS, d);
        chk({4'h0, d[3:0]}, {4'h0, s});
    endtask : st
    initial begin
        reset_n_i = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        cyc(POR_CYC - 10);
        chk({6'h00, pin_a, xtal_on}, 8'h00);
        cyc(20);
        chk({6'h00, pin_a, xtal_on}, 8'h03);
        wr(ADDR_OPCMD, {3'h0, CMD_STBY});
        st(ST_XTAL);
        cyc(XTAL_FIRST_CYC - 200);
        st(ST_XTAL);
        cyc(400);
        st(ST_CAL);
        cyc(CAL_CYC - 400);
        st(ST_CAL);
        cyc(400);
        st(ST_SLEEP);
        chk({6'h00, xtal_on, fifo_acc}, 8'h00);
        wr(ADDR_OPCMD, 8'h03);
        st(ST_SLEEP);
        rd(8'h3f, v);
        chk(v, 8'h00);
        $display("test power-up done");
        wr(ADDR_OPCMD, {3'h0, CMD_NVM});
        st(ST_NVM);
        chk({7'h00, nvm_acc}, 8'h01);
        wr(ADDR_NVM_ADR, 8'h1f);
        wr(ADDR_NVM_DAT, 8'h5a);
        rd(ADDR_NVM_DAT, v);
        chk(v, 8'h5a);
        wr(ADDR_OPCMD, {3'h0, CMD_SLEEP});
        st(ST_SLEEP);
        wr(ADDR_XTAL_LO, 8'h04);
        wr(ADDR_XTAL_HI, 8'h00);
        wr(ADDR_OPCMD, {3'h0, CMD_STBY});
        cyc(55);
        st(ST_WAKE);
        cyc(10);
        st(ST_STBY);
        chk({5'h00, xtal_on, synth_on, fifo_acc}, 8'h05);
        wr(ADDR_OPCMD, {3'h0, CMD_TUNE});
        cyc(TUNE_CYC - 50);
        st(ST_TUNING);
        cyc(100);
        st(ST_TUNE);
        chk({5'h00, xtal_on, synth_on, rf_on}, 8'h06);
        wr(ADDR_OPCMD, {3'h0, CMD_NVM});
        st(ST_TUNE);
        wr(ADDR_OPCMD, {3'h0, CMD_RX});
        cyc(RXON_CYC - 50);
        st(ST_RXON);
        cyc(100);
        st(ST_RX);
        chk({5'h00, synth_on, rf_on, fifo_acc}, 8'h07);
        wr(ADDR_OPCMD, {3'h0, CMD_SLEEP});
        st(ST_SLEEP);
        wr(ADDR_OPCMD, {3'h0, CMD_RX});
        cyc(65 + TUNE_CYC + RXON_CYC + 20);
        st(ST_RX);
        wr(ADDR_OPCMD, {3'h0, CMD_SLEEP});
        st(ST_SLEEP);
        $display("test states done");
        wr(ADDR_IRQ_EN, 8'h04);
        wr(ADDR_LINE_SEL, 8'h82);
        wr(ADDR_PIN_SEL, 8'h09);
        u_host.fire(2);
        u_host.fire(3);
        cyc(20);
        chk({7'h00, pin_a}, 8'h01);
        rd(ADDR_IRQ_STAT, v);
        chk(v, 8'h04);
        wr(ADDR_IRQ_CLR, 8'h04);
        cyc(4);
        chk({7'h00, pin_a}, 8'h00);
        u_host.set_auto(6'h01);
        cyc(6);
        chk({6'h00, pin_a, pin_b}, 8'h01);
        u_host.set_auto(6'h00);
        cyc(6);
        chk({7'h00, pin_b}, 8'h00);
        $display("test interrupts done");
        wr(ADDR_PIN_SEL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            logic s;
            s = i[0];
            if (i == 2) wr(ADDR_PIN_SEL, 8'hff);
            u_host.set_lines(s, ~s, s);
            cyc(4);
            // clock-out stays low in sleep since the crystal is off
            chk({4'h0, pin_a, pin_b, pin_c, pin_d}, i < 2 ? {6'h02, 1'b0, s} : {4'h0, s, ~s, s, ~s});
        end
        $display("test pins done");
        wr(ADDR_SLP_CTL, 8'h01);
        cyc(2);
        chk({7'h00, slp_on}, 8'h01);
        u_host.fire(6);
        cyc(4);
        st(ST_WAKE);
        cyc(70);
        st(ST_STBY);
        wr(ADDR_RESTART, RESTART_KEY);
        st(ST_XTAL);
        chk({6'h00, synth_on, fifo_acc}, 8'h00);
        $display("test wake and restart done");
        stop_test();
    end
endmodule : rsic_top_bench
